// File: cpu_core_datapath.sv
// cpu core datapath: registers, alu, multiply, interrupt stacking, address generation
// assumes a synchronous single-cycle memory bus and a classic wishbone master
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_datapath #(
  parameter int MulCycles = cpu_core_pkg::MUL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic irqReq,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  output logic memWe,
  output logic memRe,
  input wire logic [7:0] memRdata,
  output logic busy
);

  if (MulCycles < 9 || MulCycles > 15) begin : g_bad_mul
    $error("MulCycles out of range");
  end

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx;
    logic [5:0] spLow;
    logic [15:0] pc;
    logic [4:0] ccr;
    logic pending;
    cpu_core_pkg::core_state_t st;
    logic [4:0] op;
    cpu_core_pkg::addr_mode_t mode;
    logic [15:0] opnd;
    logic [15:0] ea;
    logic [2:0] step;
    logic [3:0] mulCnt;
    logic [15:0] prod;
    logic [7:0] mcand;
    logic inIrq;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [31:0] dat;
    logic ack;
    logic busy;
  } state_t;

  state_t s_q, s_d;

  // reset image; accumulator and index are the top 16 bits and are never reset
  localparam state_t ResetState = '{
    spLow: cpu_core_pkg::SP_LOW_MASK,
    ccr: 5'(1 << cpu_core_pkg::CCR_I),
    st: cpu_core_pkg::ST_RVEC,
    mode: cpu_core_pkg::AM_INH,
    busy: 1'b1,
    default: '0
  };
  localparam int KeptLsb = $bits(state_t) - 16;

  function automatic logic [15:0] effAddr(input cpu_core_pkg::addr_mode_t m,
                                          input logic [15:0] o, input logic [7:0] x);
    case (m)
      cpu_core_pkg::AM_DIR: effAddr = {8'h00, o[7:0]};
      cpu_core_pkg::AM_EXT: effAddr = o;
      cpu_core_pkg::AM_IX: effAddr = {8'h00, x};
      cpu_core_pkg::AM_IX1: effAddr = {8'h00, o[7:0]} + {8'h00, x};
      cpu_core_pkg::AM_IX2: effAddr = o + {8'h00, x};
      default: effAddr = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] spAddr(input logic [5:0] l);
    spAddr = cpu_core_pkg::SP_FIXED | {10'h000, l};
  endfunction

  logic [8:0] aluRes;
  logic aluHalf;
  logic [7:0] operand;
  logic wbReq;

  // ---------------------------------------------------------------
  // alu
  // ---------------------------------------------------------------
  always_comb begin
    operand = (s_q.mode == cpu_core_pkg::AM_IMM) ? s_q.opnd[7:0] : memRdata;
    aluRes = 9'h000;
    aluHalf = 1'b0;
    case (s_q.op)
      cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC: begin
        aluRes = {1'b0, s_q.acc} + {1'b0, operand}
          + {8'h00, s_q.op == cpu_core_pkg::OP_ADC && s_q.ccr[cpu_core_pkg::CCR_C]};
        aluHalf = s_q.acc[4] ^ operand[4] ^ aluRes[4];
      end
      cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SBC: begin
        aluRes = {1'b0, s_q.acc} + {1'b0, ~operand} + 9'h001
          - {8'h00, s_q.op == cpu_core_pkg::OP_SBC && s_q.ccr[cpu_core_pkg::CCR_C]};
        aluRes[8] = ~aluRes[8];
      end
      cpu_core_pkg::OP_AND: aluRes = {1'b0, s_q.acc & operand};
      cpu_core_pkg::OP_ORA: aluRes = {1'b0, s_q.acc | operand};
      cpu_core_pkg::OP_EOR: aluRes = {1'b0, s_q.acc ^ operand};
      cpu_core_pkg::OP_BUMP_ACCUMULATOR_INSTR: aluRes = {1'b0, s_q.acc + 8'h01};
      default: aluRes = {1'b0, operand};
    endcase
  end

  assign wbReq = wb_cyc_i && wb_stb_i && !s_q.ack;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.re = 1'b0;
    s_d.ack = 1'b0;
    if (irqReq) begin
      s_d.pending = 1'b1;
    end
    case (s_q.st)
      cpu_core_pkg::ST_RVEC: begin
        // high byte first, then low byte
        s_d.re = 1'b1;
        if (s_q.step == 3'd0) begin
          s_d.addr = cpu_core_pkg::VEC_RESET;
          s_d.step = 3'd1;
        end else if (s_q.step == 3'd1) begin
          s_d.addr = cpu_core_pkg::VEC_RESET + 16'h0001;
          s_d.step = 3'd2;
        end else if (s_q.step == 3'd2) begin
          s_d.pc[15:8] = memRdata;
          s_d.step = 3'd3;
          s_d.re = 1'b0;
        end else begin
          s_d.pc[7:0] = memRdata;
          s_d.st = cpu_core_pkg::ST_IDLE;
          s_d.re = 1'b0;
          s_d.step = 3'd0;
        end
      end
      cpu_core_pkg::ST_IDLE: begin
        s_d.busy = 1'b0;
        if ((s_q.pending || irqReq) && !s_q.ccr[cpu_core_pkg::CCR_I]) begin
          s_d.st = cpu_core_pkg::ST_PUSH;
          s_d.inIrq = 1'b1;
          s_d.step = 3'd0;
          s_d.pending = 1'b0;
          s_d.busy = 1'b1;
        end
      end
      cpu_core_pkg::ST_MEMRD: begin
        // issue the read, then wait a cycle for the data to stand
        s_d.addr = s_q.ea;
        if (s_q.step == 3'd0) begin
          s_d.re = 1'b1;
          s_d.step = 3'd1;
        end else begin
          s_d.step = 3'd0;
          s_d.st = cpu_core_pkg::ST_EXEC;
        end
      end
      cpu_core_pkg::ST_EXEC: begin
        s_d.st = cpu_core_pkg::ST_IDLE;
        case (s_q.op)
          cpu_core_pkg::OP_LDX: s_d.idx = aluRes[7:0];
          default: s_d.acc = aluRes[7:0];
        endcase
        s_d.ccr[cpu_core_pkg::CCR_N] = aluRes[7];
        s_d.ccr[cpu_core_pkg::CCR_Z] = aluRes[7:0] == 8'h00;
        if (s_q.op inside {cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC}) begin
          s_d.ccr[cpu_core_pkg::CCR_H] = aluHalf;
        end
        if (s_q.op inside {cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC,
                           cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SBC}) begin
          s_d.ccr[cpu_core_pkg::CCR_C] = aluRes[8];
        end
      end
      cpu_core_pkg::ST_MUL: begin
        // shift-add over the eight multiplier bits, then MulCycles-8 more cycles, writing back in the last
        if (s_q.mulCnt < 4'd8) begin
          s_d.prod = s_q.prod[0]
            ? {{1'b0, s_q.prod[15:8]} + {1'b0, s_q.mcand}, s_q.prod[7:1]}
            : {1'b0, s_q.prod[15:1]};
        end
        s_d.mulCnt = s_q.mulCnt + 4'd1;
        if (s_q.mulCnt == 4'(MulCycles - 1)) begin
          s_d.idx = s_q.prod[15:8];
          s_d.acc = s_q.prod[7:0];
          s_d.ccr[cpu_core_pkg::CCR_H] = 1'b0;
          s_d.ccr[cpu_core_pkg::CCR_C] = 1'b0;
          s_d.st = cpu_core_pkg::ST_IDLE;
          s_d.busy = 1'b0;
        end
      end
      cpu_core_pkg::ST_PUSH: begin
        // interrupt stacks pcl, pch, x, a, ccr; a call stacks pcl, pch
        s_d.we = 1'b1;
        s_d.addr = spAddr(s_q.spLow);
        s_d.spLow = s_q.spLow - 6'd1;
        case (s_q.step)
          3'd0: s_d.wdata = s_q.pc[7:0];
          3'd1: s_d.wdata = s_q.pc[15:8];
          3'd2: s_d.wdata = s_q.idx;
          3'd3: s_d.wdata = s_q.acc;
          default: s_d.wdata = {3'b111, s_q.ccr};
        endcase
        s_d.step = s_q.step + 3'd1;
        if (!s_q.inIrq && s_q.step == 3'd1) begin
          s_d.pc = s_q.ea;
          s_d.st = cpu_core_pkg::ST_IDLE;
        end else if (s_q.step == 3'd4) begin
          s_d.ccr[cpu_core_pkg::CCR_I] = 1'b1;
          s_d.st = cpu_core_pkg::ST_VEC;
          s_d.step = 3'd0;
        end
      end
      cpu_core_pkg::ST_VEC: begin
        s_d.re = 1'b1;
        s_d.step = s_q.step + 3'd1;
        if (s_q.step == 3'd0) s_d.addr = cpu_core_pkg::VEC_IRQ;
        else if (s_q.step == 3'd1) s_d.addr = cpu_core_pkg::VEC_IRQ + 16'h0001;
        else if (s_q.step == 3'd2) s_d.pc[15:8] = memRdata;
        else begin
          s_d.pc[7:0] = memRdata;
          s_d.st = cpu_core_pkg::ST_IDLE;
          s_d.inIrq = 1'b0;
          s_d.re = 1'b0;
        end
      end
      cpu_core_pkg::ST_PULL: begin
        // pull in reverse; issue address, wait, capture two cycles later
        s_d.step = s_q.step + 3'd1;
        if (s_q.step == 3'd0) begin
          s_d.spLow = s_q.spLow + 6'd1;
          s_d.addr = spAddr(s_q.spLow + 6'd1);
          s_d.re = 1'b1;
        end else if (s_q.step == 3'd2) begin
          s_d.step = 3'd0;
          case (s_q.mulCnt)
            4'd0: s_d.ccr = s_q.inIrq ? memRdata[4:0] : s_q.ccr;
            4'd1: s_d.acc = memRdata;
            4'd2: s_d.idx = memRdata;
            4'd3: s_d.pc[15:8] = memRdata;
            default: s_d.pc[7:0] = memRdata;
          endcase
          s_d.mulCnt = s_q.mulCnt + 4'd1;
          if (s_q.mulCnt == 4'd4) begin
            s_d.st = cpu_core_pkg::ST_IDLE;
            s_d.inIrq = 1'b0;
          end
        end
      end
      default: s_d.st = cpu_core_pkg::ST_IDLE;
    endcase

    // ---------------------------------------------------------------
    // wishbone slave
    // ---------------------------------------------------------------
    if (wbReq) begin
      s_d.ack = 1'b1;
      s_d.dat = 32'h0000_0000;
      if (wb_adr_i == cpu_core_pkg::OFF_ACC) begin
        s_d.dat = {24'h000000, s_q.acc};
        if (wb_we_i && wb_sel_i[0] && s_q.st == cpu_core_pkg::ST_IDLE) s_d.acc = wb_dat_i[7:0];
      end else if (wb_adr_i == cpu_core_pkg::OFF_IDX) begin
        s_d.dat = {24'h000000, s_q.idx};
        if (wb_we_i && wb_sel_i[0] && s_q.st == cpu_core_pkg::ST_IDLE) s_d.idx = wb_dat_i[7:0];
      end else if (wb_adr_i == cpu_core_pkg::OFF_SP) begin
        s_d.dat = {16'h0000, spAddr(s_q.spLow)};
      end else if (wb_adr_i == cpu_core_pkg::OFF_PC) begin
        s_d.dat = {16'h0000, s_q.pc};
        if (wb_we_i && wb_sel_i[1:0] == 2'b11 && s_q.st == cpu_core_pkg::ST_IDLE) begin
          s_d.pc = wb_dat_i[15:0];
        end
      end else if (wb_adr_i == cpu_core_pkg::OFF_CCR) begin
        s_d.dat = {27'h0000000, s_q.ccr};
      end else if (wb_adr_i == cpu_core_pkg::OFF_OPND) begin
        s_d.dat = {16'h0000, s_q.opnd};
        if (wb_we_i && s_q.st == cpu_core_pkg::ST_IDLE) s_d.opnd = wb_dat_i[15:0];
      end else if (wb_adr_i == cpu_core_pkg::OFF_EA) begin
        s_d.dat = {16'h0000, s_q.ea};
      end else if (wb_adr_i == cpu_core_pkg::OFF_STAT) begin
        s_d.dat = {27'h0000000, s_q.pending, s_q.st};
      end else if (wb_adr_i == cpu_core_pkg::OFF_CMD) begin
        s_d.dat = {24'h000000, s_q.mode, s_q.op};
        if (wb_we_i && wb_sel_i[0] && s_q.st == cpu_core_pkg::ST_IDLE) begin
          s_d.op = wb_dat_i[4:0];
          s_d.mode = cpu_core_pkg::addr_mode_t'(wb_dat_i[7:5]);
          s_d.ea = effAddr(cpu_core_pkg::addr_mode_t'(wb_dat_i[7:5]), s_q.opnd, s_q.idx);
          s_d.busy = 1'b1;
          s_d.step = 3'd0;
          s_d.mulCnt = 4'd0;
          // opcode fetch plus operand bytes per mode
          case (cpu_core_pkg::addr_mode_t'(wb_dat_i[7:5]))
            cpu_core_pkg::AM_INH, cpu_core_pkg::AM_IX: s_d.pc = s_q.pc + 16'd1;
            cpu_core_pkg::AM_EXT, cpu_core_pkg::AM_IX2: s_d.pc = s_q.pc + 16'd3;
            default: s_d.pc = s_q.pc + 16'd2;
          endcase
          case (wb_dat_i[4:0])
            cpu_core_pkg::OP_MUL: begin
              s_d.st = cpu_core_pkg::ST_MUL;
              s_d.prod = {8'h00, s_q.acc};
              s_d.mcand = s_q.idx;
            end
            cpu_core_pkg::OP_RSP: begin
              s_d.spLow = cpu_core_pkg::SP_LOW_MASK;
              s_d.busy = 1'b0;
            end
            cpu_core_pkg::OP_SEC: begin
              s_d.ccr[cpu_core_pkg::CCR_C] = 1'b1;
              s_d.busy = 1'b0;
            end
            cpu_core_pkg::OP_CLI: begin
              s_d.ccr[cpu_core_pkg::CCR_I] = 1'b0;
              s_d.busy = 1'b0;
            end
            cpu_core_pkg::OP_SEI: begin
              s_d.ccr[cpu_core_pkg::CCR_I] = 1'b1;
              s_d.busy = 1'b0;
            end
            cpu_core_pkg::OP_BUMP_ACCUMULATOR_INSTR: s_d.st = cpu_core_pkg::ST_EXEC;
            cpu_core_pkg::OP_RTI: begin
              s_d.st = cpu_core_pkg::ST_PULL;
              s_d.inIrq = 1'b1;
            end
            cpu_core_pkg::OP_RTS: begin
              s_d.st = cpu_core_pkg::ST_PULL;
              s_d.mulCnt = 4'd3;
            end
            cpu_core_pkg::OP_JMP: begin
              s_d.pc = effAddr(cpu_core_pkg::addr_mode_t'(wb_dat_i[7:5]), s_q.opnd, s_q.idx);
              s_d.busy = 1'b0;
            end
            cpu_core_pkg::OP_JSR: begin
              s_d.st = cpu_core_pkg::ST_PUSH;
              s_d.inIrq = 1'b0;
            end
            cpu_core_pkg::OP_NOP: s_d.busy = 1'b0;
            default: begin
              if (cpu_core_pkg::addr_mode_t'(wb_dat_i[7:5]) == cpu_core_pkg::AM_IMM) begin
                s_d.st = cpu_core_pkg::ST_EXEC;
              end else begin
                s_d.st = cpu_core_pkg::ST_MEMRD;
              end
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // accumulator and index keep their value through reset
      s_q[KeptLsb-1:0] <= ResetState[KeptLsb-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign memAddr = s_q.addr & cpu_core_pkg::PC_ADDR_MASK;
  assign memWdata = s_q.wdata;
  assign memWe = s_q.we;
  assign memRe = s_q.re;
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign busy = s_q.busy;

endmodule // cpu_core_datapath

`default_nettype wire

// File: cpu_core_datapath_checker.sv
// checker: port-level assertions for the cpu core datapath
// assumes it is bound to cpu_core_datapath below
`timescale 1ns/1ps
`default_nettype none
module cpu_core_datapath_checker #(
  parameter int MulCycles = cpu_core_pkg::MUL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irqReq,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic memWe,
  input wire logic memRe,
  input wire logic [7:0] memRdata,
  input wire logic busy
);
  localparam int MulTail = MulCycles - 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic taken;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence vecHi; memRe && memAddr == 16'h1FFE; endsequence
  sequence vecLo; memRe && memAddr == 16'h1FFF; endsequence
  sequence mulCmd;
    taken && wb_we_i && !busy && wb_adr_i == cpu_core_pkg::OFF_CMD
      && wb_dat_i[4:0] == cpu_core_pkg::OP_MUL;
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  ack_next_a: assert property (taken |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  unmapped_zero_a: assert property (taken && !wb_we_i && wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  mem_top_a: assert property ((memRe || memWe) |-> memAddr[15:14] == 2'h0)
    else $error("memory address top bits set");
  stack_page_a: assert property (memWe |-> memAddr[15:6] == 10'h003)
    else $error("stack write outside stack page");
  boot_read_a: assert property ($rose(rst_n) |-> busy ##[0:6] vecHi)
    else $error("reset vector not fetched");
  vec_order_a: assert property (vecHi |-> ##[1:3] vecLo)
    else $error("vector low byte not fetched after high byte");
  mul_span_a: assert property (mulCmd |-> ##1 busy [*8] ##[MulTail:MulTail] busy ##1 !busy)
    else $error("multiply duration wrong");
endmodule // cpu_core_datapath_checker
bind cpu_core_datapath cpu_core_datapath_checker #(.MulCycles(MulCycles)) u_cpu_core_datapath_checker (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irqReq(irqReq), .memAddr(memAddr), .memWdata(memWdata),
  .memWe(memWe), .memRe(memRe), .memRdata(memRdata), .busy(busy));
`default_nettype wire

// File: cpu_core_datapath_tb_top.sv
// testbench: wishbone driver, behavioural model, memory partner
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`default_nettype none
module cpu_core_datapath_tb_top;
  logic clk, rst_n, wbCyc, wbStb, wbWe, wbAck, irqReq, memWe, memRe, busy, waitPend;
  logic [7:0] wbAdr, memWdata, memRdata;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [15:0] memAddr;
  logic [4:0] op;
  cpu_core_pkg::addr_mode_t modes [6];
  int err_count, n_compared, cycles, a, x, c, h, r, b, ci, e, sp;
  cpu_core_datapath u_cpu_core_datapath (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(4'hF),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irqReq(irqReq), .memAddr(memAddr),
    .memWdata(memWdata), .memWe(memWe), .memRe(memRe), .memRdata(memRdata), .busy(busy));
  cpu_mem_model u_cpu_mem_model (.clk(clk), .memAddr(memAddr), .memWdata(memWdata),
    .memWe(memWe), .memRe(memRe), .memRdata(memRdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= ad;
    wbDatI <= d;
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic idle();
    do begin
      wb(1'b0, cpu_core_pkg::OFF_STAT, 32'h0);
    end while (rd[3:0] !== cpu_core_pkg::ST_IDLE || (waitPend && rd[4]));
  endtask
  task automatic run(input logic [4:0] o, input logic [2:0] m, input logic [15:0] opnd);
    wb(1'b1, cpu_core_pkg::OFF_OPND, {16'h0, opnd});
    wb(1'b1, cpu_core_pkg::OFF_CMD, {24'h0, m, o});
    idle();
  endtask
  task automatic chkReg(input logic [7:0] ad, input int exp);
    wb(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask
  task automatic ccrBit(input int pos, input int exp);
    wb(1'b0, cpu_core_pkg::OFF_CCR, 32'h0);
    check(rd[pos], exp);
  endtask
  task automatic irqPulse();
    @(posedge clk);
    irqReq <= 1'b1;
    @(posedge clk);
    irqReq <= 1'b0;
    idle();
  endtask
  function automatic int fill(input int ad);
    return (ad & 1) ? ((ad & 255) ^ 8'h5A) : (ad & 31);
  endfunction
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, wbCyc, wbStb, wbWe, irqReq} = 5'h0;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    waitPend = 1'b1;
    modes = '{cpu_core_pkg::AM_DIR, cpu_core_pkg::AM_EXT, cpu_core_pkg::AM_IX,
      cpu_core_pkg::AM_IX1, cpu_core_pkg::AM_IX1, cpu_core_pkg::AM_IX2};
    void'($urandom(32'hBAB1));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FF);
    ccrBit(cpu_core_pkg::CCR_I, 1);
    chkReg(cpu_core_pkg::OFF_PC, 32'h1EA5);
    chkReg(8'h40, 32'h0);
    a = $urandom_range(0, 255);
    wb(1'b1, cpu_core_pkg::OFF_ACC, a);
    run(cpu_core_pkg::OP_SEC, cpu_core_pkg::AM_INH, 16'h0);
    c = 1;
    ccrBit(cpu_core_pkg::CCR_C, c);
    for (int i = 0; i < 40; i++) begin
      op = 5'($urandom_range(1, 8));
      b = $urandom_range(0, 255);
      ci = (op == cpu_core_pkg::OP_ADC || op == cpu_core_pkg::OP_SBC) ? c : 0;
      case (op)
        cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC: begin
          h = ((a & 15) + (b & 15) + ci) > 15;
          r = a + b + ci;
          c = r > 255;
        end
        cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SBC: begin
          r = a - b - ci;
          c = r < 0;
        end
        cpu_core_pkg::OP_AND: r = a & b;
        cpu_core_pkg::OP_ORA: r = a | b;
        cpu_core_pkg::OP_EOR: r = a ^ b;
        default: r = b;
      endcase
      a = r & 255;
      run(op, cpu_core_pkg::AM_IMM, 16'(b));
      chkReg(cpu_core_pkg::OFF_ACC, a);
      wb(1'b0, cpu_core_pkg::OFF_CCR, 32'h0);
      check(rd[cpu_core_pkg::CCR_N], (a >> 7) & 1);
      check(rd[cpu_core_pkg::CCR_Z], a == 0);
      check(rd[cpu_core_pkg::CCR_C], c);
      if (op <= cpu_core_pkg::OP_ADC) check(rd[cpu_core_pkg::CCR_H], h);
    end
    wb(1'b1, cpu_core_pkg::OFF_ACC, 32'hFF);
    run(cpu_core_pkg::OP_BUMP_ACCUMULATOR_INSTR, cpu_core_pkg::AM_INH, 16'h0);
    ccrBit(cpu_core_pkg::CCR_Z, 1);
    for (int m = 0; m < 6; m++) begin
      x = (m == 4) ? 255 : $urandom_range(0, 95);
      b = ($urandom_range(0, 255) << 8) | ((m == 4) ? 255 : $urandom_range(0, 95));
      if (m == 1 || m == 5) b = $urandom_range(256, 16'h1FFF);
      e = (m == 1) ? b : (m == 2) ? x : (m == 5) ? b + x : (b & 255) + ((m >= 3) ? x : 0);
      wb(1'b1, cpu_core_pkg::OFF_IDX, x);
      run(cpu_core_pkg::OP_LDA, modes[m], 16'(b));
      chkReg(cpu_core_pkg::OFF_EA, e);
      chkReg(cpu_core_pkg::OFF_ACC, fill(e));
    end
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 255 : $urandom_range(0, 255);
      x = (i == 0) ? 255 : $urandom_range(0, 255);
      wb(1'b1, cpu_core_pkg::OFF_ACC, a);
      wb(1'b1, cpu_core_pkg::OFF_IDX, x);
      run(cpu_core_pkg::OP_MUL, cpu_core_pkg::AM_INH, 16'h0);
      r = a * x;
      a = r & 255;
      x = r >> 8;
      chkReg(cpu_core_pkg::OFF_ACC, a);
      chkReg(cpu_core_pkg::OFF_IDX, x);
    end
    sp = 255;
    for (int i = 0; i < 33; i++) begin
      run(cpu_core_pkg::OP_JSR, cpu_core_pkg::AM_EXT, 16'h0400 + 16'(i));
      sp = 16'h00C0 | ((sp - 2) & 63);
    end
    chkReg(cpu_core_pkg::OFF_SP, sp);
    chkReg(cpu_core_pkg::OFF_PC, 16'h0420);
    run(cpu_core_pkg::OP_RTS, cpu_core_pkg::AM_INH, 16'h0);
    chkReg(cpu_core_pkg::OFF_PC, 32'h0422);
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FF);
    run(cpu_core_pkg::OP_JSR, cpu_core_pkg::AM_EXT, 16'h0123);
    run(cpu_core_pkg::OP_RSP, cpu_core_pkg::AM_INH, 16'h0);
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FF);
    run(cpu_core_pkg::OP_JMP, cpu_core_pkg::AM_EXT, 16'h0123);
    chkReg(cpu_core_pkg::OFF_PC, 32'h0123);
    run(cpu_core_pkg::OP_CLI, cpu_core_pkg::AM_INH, 16'h0);
    irqPulse();
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FA);
    chkReg(cpu_core_pkg::OFF_PC, 32'h1AA1);
    ccrBit(cpu_core_pkg::CCR_I, 1);
    run(cpu_core_pkg::OP_RTI, cpu_core_pkg::AM_INH, 16'h0);
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FF);
    ccrBit(cpu_core_pkg::CCR_I, 0);
    run(cpu_core_pkg::OP_SEI, cpu_core_pkg::AM_INH, 16'h0);
    waitPend = 1'b0;
    irqPulse();
    wb(1'b0, cpu_core_pkg::OFF_STAT, 32'h0);
    check(rd[4], 1);
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FF);
    waitPend = 1'b1;
    run(cpu_core_pkg::OP_CLI, cpu_core_pkg::AM_INH, 16'h0);
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FA);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    chkReg(cpu_core_pkg::OFF_ACC, a);
    chkReg(cpu_core_pkg::OFF_IDX, x);
    chkReg(cpu_core_pkg::OFF_SP, 32'h00FF);
    ccrBit(cpu_core_pkg::CCR_I, 1);
    summarize();
  end
endmodule // cpu_core_datapath_tb_top
`default_nettype wire

// File: cpu_core_pkg.sv
// constants and types for the 8-bit cpu core datapath
// assumes a single clock domain and a classic wishbone register port
package cpu_core_pkg;

  // register offsets on the wishbone port (byte addresses)
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_IDX = 8'h04;
  localparam logic [7:0] OFF_SP = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_CCR = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_OPND = 8'h18;
  localparam logic [7:0] OFF_EA = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;

  // condition code field positions
  localparam int CCR_C = 0;
  localparam int CCR_Z = 1;
  localparam int CCR_N = 2;
  localparam int CCR_I = 3;
  localparam int CCR_H = 4;

  // reset values, stack page, vectors and address mask
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [15:0] SP_FIXED = 16'h00C0;
  localparam logic [5:0] SP_LOW_MASK = 6'h3F;
  localparam logic [15:0] VEC_RESET = 16'h1FFE;
  localparam logic [15:0] VEC_IRQ = 16'h1FFA;
  localparam logic [15:0] PC_ADDR_MASK = 16'h3FFF;

  // timing
  localparam int MUL_CYCLES = 11;

  // command codes written to the command register
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_ADD = 5'h01;
  localparam logic [4:0] OP_ADC = 5'h02;
  localparam logic [4:0] OP_SUB = 5'h03;
  localparam logic [4:0] OP_SBC = 5'h04;
  localparam logic [4:0] OP_AND = 5'h05;
  localparam logic [4:0] OP_ORA = 5'h06;
  localparam logic [4:0] OP_EOR = 5'h07;
  localparam logic [4:0] OP_LDA = 5'h08;
  localparam logic [4:0] OP_LDX = 5'h09;
  localparam logic [4:0] OP_MUL = 5'h0A;
  localparam logic [4:0] OP_RSP = 5'h0B;
  localparam logic [4:0] OP_SEC = 5'h0C;
  localparam logic [4:0] OP_BUMP_ACCUMULATOR_INSTR = 5'h0D;
  localparam logic [4:0] OP_CLI = 5'h0E;
  localparam logic [4:0] OP_SEI = 5'h0F;
  localparam logic [4:0] OP_RTI = 5'h10;
  localparam logic [4:0] OP_JMP = 5'h11;
  localparam logic [4:0] OP_JSR = 5'h12;
  localparam logic [4:0] OP_RTS = 5'h13;
  localparam logic [4:0] OP_FETCH = 5'h14;

  // addressing modes
  typedef enum logic [2:0] {
    AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX, AM_IX1, AM_IX2, AM_REL
  } addr_mode_t;

  typedef enum logic [3:0] {
    ST_RVEC, ST_IDLE, ST_MEMRD, ST_EXEC, ST_MUL, ST_PUSH, ST_PULL, ST_VEC
  } core_state_t;

endpackage : cpu_core_pkg

// File: cpu_mem_model.sv
// memory partner: byte memory with a fixed fill pattern, stack writes kept
// assumes read data is wanted the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model (
  input wire logic clk,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic memWe,
  input wire logic memRe,
  output logic [7:0] memRdata
);
  logic [7:0] store [logic [15:0]];
  // even bytes small so vectors stay inside the 14-bit space
  function automatic logic [7:0] fill(input logic [15:0] ad);
    return ad[0] ? (ad[7:0] ^ 8'h5A) : {3'h0, ad[4:0]};
  endfunction
  initial memRdata = 8'hFF;
  always @(posedge clk) begin
    if (memWe) store[memAddr] = memWdata;
    if (memRe) memRdata <= store.exists(memAddr) ? store[memAddr] : fill(memAddr);
    else memRdata <= ~memRdata; // released bus never holds the last value
  end
endmodule // cpu_mem_model
`default_nettype wire
